// File: adc_code_path.sv
// Purpose: Digital control and code path of a single-channel scanner front end.
// Assumes: pclk is the master clock; sample_strobe and adc_raw come from pins.
// Notes:   Words leave as four nibbles, buffered through a 32-word FIFO.
//          Pin inputs pass two flops before any logic reads them.
//
// The register offsets and the APB register port were left to the implementer.
`timescale 1ns/1ps
// What this block does
// - Colour select 00/01/10 picks red/green/blue codes
// - Monochrome applies one fixed code pair
// - Clamp enable sampled during strobe pulse
// - Clamp pulse from clock, strobe, enable
// - Reset-sample position shifts clamp timing
// - CORRELATED_DOUBLE_SAMPLING bit picks reset-level or pin reference
// - External ref select disables clamp DAC
// - Four-bit clamp level code plus range bit
// - Three stored eight-bit offset/gain pairs
// - ADC range places zero top/bottom/middle
// - Add offset, saturate sixteen-bit result
// - Invert gives 65535 minus code
// - Nibble bus with selectable latency
// - Mode 2 holds each nibble two cycles
// - Nibbles most significant first
// - Sample on third edge after strobe low
module adc_code_path
  import adc_pkg::*;
#(
  parameter int FIFO_WORDS = FIFO_DEPTH
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Register bus
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Pins from the scanner controller
  input  wire logic        sample_strobe,
  input  wire logic [16:0] adc_raw,
  // Analogue channel controls
  output logic      [7:0]  offset_dac_code,
  output logic      [7:0]  gain_amplifier_code,
  output logic             clamp_pulse,
  output logic             reset_sample_pulse,
  output logic             video_sample_pulse,
  output logic             correlated_double_sampling,
  output logic             clamp_level_dac_enable,
  output logic             reference_level_pin_oe_n,
  output logic      [3:0]  clamp_level_code,
  output logic             clamp_dac_range,
  // Multiplexed result port
  output logic      [3:0]  output_nibble_bus,
  output logic             nibble_valid
);
  // Binary buffer pointers need a power-of-two depth
  if (FIFO_WORDS < 2 || (1 << $clog2(FIFO_WORDS)) != FIFO_WORDS) begin : g_bad_depth
    $error("FIFO_WORDS must be a power of two, at least 2");
  end

  // Register state
  logic [CFG_WIDTH-1:0] cfg;
  logic [15:0]          red_coef;
  logic [15:0]          green_coef;
  logic [15:0]          blue_coef;
  logic [15:0]          last_word;
  logic                 overflow;
  // Pin synchronisers
  logic                 strobe_s1;
  logic                 strobe_s2;
  logic                 strobe_d;
  logic [16:0]          raw_s1;
  logic [16:0]          raw_s2;
  // Clamp and reset-sample timing
  logic                 clamp_latched;
  logic [1:0]           pos_cnt;
  logic                 pos_run;
  logic                 take_sample;
  // Latency pipe and buffer handshake
  logic [2:0]           lat_pipe;
  logic [15:0]          word_q;
  logic                 word_pending;
  logic [15:0]          next_code;
  logic                 fifo_in_ready;
  logic                 fifo_out_valid;
  logic [15:0]          fifo_out_data;
  logic                 fifo_pop;
  // Serialiser
  logic [15:0]          shift_word;
  logic [1:0]           nib_idx;
  logic                 shifting;
  logic                 mode2_gap;
  // Bus decode
  logic                 apb_write;
  logic                 apb_read;

  // Decode a byte address into a hit on one register
  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    return a == off;
  endfunction

  // Write at the access edge, read at setup
  assign apb_write = psel && penable && pwrite;
  assign apb_read  = psel && !penable && !pwrite;

  // Configuration and coefficient registers
  // Unmapped writes change nothing;
  // status and result are read-only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg        <= CFG_RESET[CFG_WIDTH-1:0];
      red_coef   <= COEF_RESET[15:0];
      green_coef <= COEF_RESET[15:0];
      blue_coef  <= COEF_RESET[15:0];
    end else if (apb_write) begin
      if (hit(paddr, CFG_OFFSET))   cfg        <= pwdata[CFG_WIDTH-1:0];
      if (hit(paddr, RED_OFFSET))   red_coef   <= pwdata[15:0];
      if (hit(paddr, GREEN_OFFSET)) green_coef <= pwdata[15:0];
      if (hit(paddr, BLUE_OFFSET))  blue_coef  <= pwdata[15:0];
    end
  end

  // Read data is staged in the setup cycle, so every access takes one wait-free phase
  // Limitation: no wait states, ever;
  // pready follows setup by one edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= '0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !(hit(paddr, CFG_OFFSET) || hit(paddr, RED_OFFSET)
                 || hit(paddr, GREEN_OFFSET) || hit(paddr, BLUE_OFFSET)
                 || hit(paddr, STATUS_OFFSET) || hit(paddr, RESULT_OFFSET));
      // Held until the next read
      if (apb_read) begin
        case (paddr)
          CFG_OFFSET:    prdata <= {{(32-CFG_WIDTH){1'b0}}, cfg};
          RED_OFFSET:    prdata <= {16'h0000, red_coef};
          GREEN_OFFSET:  prdata <= {16'h0000, green_coef};
          BLUE_OFFSET:   prdata <= {16'h0000, blue_coef};
          STATUS_OFFSET: prdata <= {29'h0000_0000, overflow, fifo_out_valid, clamp_latched};
          RESULT_OFFSET: prdata <= {16'h0000, last_word};
          default:       prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Strobe and converter code come from outside; two flops before use
  // The code is held around the strobe,
  // so it needs no gray coding here;
  // flop three only serves the edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strobe_s1 <= 1'b0;
      strobe_s2 <= 1'b0;
      strobe_d  <= 1'b0;
      raw_s1    <= '0;
      raw_s2    <= '0;
    end else begin
      strobe_s1 <= sample_strobe;
      strobe_s2 <= strobe_s1;
      strobe_d  <= strobe_s2;
      raw_s1    <= adc_raw;
      raw_s2    <= raw_s1;
    end
  end

  // Falling strobe marks the sampling edge
  // It lands three edges after the pin
  // falls, the price of two sync flops;
  // idle low after reset, no false edge
  assign take_sample = strobe_d && !strobe_s2;

  // Clamp enable latched while strobe is high; it governs the next reset level
  // A later write cannot cut a clamp
  // that is already decided
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clamp_latched <= 1'b0;
    end else if (strobe_s2) begin
      clamp_latched <= cfg[CFG_CLAMP_EN];
    end
  end

  // Reset-level sample and clamp pulse placed after the sample by a position count
  // A new sample restarts the count;
  // strobes tighter than the position
  // lose the earlier pixel's clamp
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pos_cnt            <= 2'h0;
      pos_run            <= 1'b0;
      clamp_pulse        <= 1'b0;
      reset_sample_pulse <= 1'b0;
      video_sample_pulse <= 1'b0;
    end else begin
      // Pulses drop unless reloaded
      video_sample_pulse <= take_sample;
      reset_sample_pulse <= 1'b0;
      clamp_pulse        <= 1'b0;
      if (take_sample) begin
        pos_cnt <= cfg[CFG_POS_LSB +: 2];
        pos_run <= 1'b1;
      end else if (pos_run) begin
        if (pos_cnt == 2'h0) begin
          pos_run            <= 1'b0;
          reset_sample_pulse <= cfg[CFG_CDS_BIT];
          clamp_pulse        <= clamp_latched;
        end else begin
          pos_cnt <= pos_cnt - 2'h1;
        end
      end
    end
  end

  // Coefficients held per pixel and updated only at a sample; reference setup follows cfg
  // Reference controls are static
  // settings and track at once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      offset_dac_code            <= 8'h00;
      gain_amplifier_code        <= 8'h00;
      correlated_double_sampling <= 1'b1;
      clamp_level_dac_enable     <= 1'b1;
      reference_level_pin_oe_n   <= 1'b0;
      clamp_level_code           <= 4'h0;
      clamp_dac_range            <= 1'b0;
    end else begin
      correlated_double_sampling <= cfg[CFG_CDS_BIT];
      clamp_level_dac_enable     <= !cfg[CFG_EXTREF_BIT];
      reference_level_pin_oe_n   <= cfg[CFG_EXTREF_BIT];
      clamp_level_code           <= cfg[CFG_LEVEL_LSB +: 4];
      clamp_dac_range            <= cfg[CFG_DACRNG_BIT];
      // Offset and gain move at a sample
      if (take_sample) begin
        if (cfg[CFG_MONO_BIT]) begin
          {gain_amplifier_code, offset_dac_code} <= red_coef;
        end else begin
          case (cfg[CFG_COLOUR_LSB +: 2])
            2'h0:    {gain_amplifier_code, offset_dac_code} <= red_coef;
            2'h1:    {gain_amplifier_code, offset_dac_code} <= green_coef;
            2'h2:    {gain_amplifier_code, offset_dac_code} <= blue_coef;
            default: ;  // Reserved code keeps the previous pair
          endcase
        end
      end
    end
  end

  // Signed converter value offset per range, saturated, optionally inverted
  // Range sets where zero input lands
  // Nineteen bits hold sign and sum
  // Clip first, so inverted clips hold
  always_comb begin
    logic signed [18:0] sum;
    sum = 19'sd0;
    case (cfg[CFG_RANGE_LSB +: 2])
      RANGE_TOP: sum = $signed({{2{raw_s2[16]}}, raw_s2}) + $signed({2'b00, TOP_OFFSET});
      RANGE_BOT: sum = $signed({{2{raw_s2[16]}}, raw_s2});
      default:   sum = $signed({{2{raw_s2[16]}}, raw_s2}) + $signed({2'b00, MID_OFFSET});
    endcase
    if (sum < 0) begin
      next_code = 16'h0000;
    end else if (sum > $signed({3'b000, FULL_CODE})) begin
      next_code = FULL_CODE;
    end else begin
      next_code = sum[15:0];
    end
    if (cfg[CFG_INVERT_BIT]) begin
      next_code = FULL_CODE - next_code;
    end
  end

  // Latency pipe: the word is offered to the FIFO 0..3 cycles after the sample
  // Trade-off: one holding register;
  // a second sample in the window
  // replaces the first
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lat_pipe     <= 3'h0;
      word_q       <= 16'h0000;
      word_pending <= 1'b0;
      last_word    <= 16'h0000;
      overflow     <= 1'b0;
    end else begin
      lat_pipe <= {lat_pipe[1:0], take_sample};
      if (take_sample) begin
        word_q <= next_code;
      end
      if (word_pending && fifo_in_ready) begin
        word_pending <= 1'b0;
        last_word    <= word_q;
      end
      // Offer the word once latency ends
      case (cfg[CFG_LAT_LSB +: 2])
        2'h0:    if (take_sample) word_pending <= 1'b1;
        2'h1:    if (lat_pipe[0]) word_pending <= 1'b1;
        2'h2:    if (lat_pipe[1]) word_pending <= 1'b1;
        default: if (lat_pipe[2]) word_pending <= 1'b1;
      endcase
      // A full FIFO stalls the path; a sample arriving while stalled overwrites the stalled word, which is counted lost
      if (take_sample && word_pending && !fifo_in_ready) begin
        overflow <= 1'b1;
      end else if (apb_read && hit(paddr, STATUS_OFFSET)) begin
        overflow <= 1'b0;
      end
    end
  end

  // Buffer absorbs bursts faster
  // than the port drains;
  // depth is the module parameter
  adc_fifo #(
    .WIDTH (16),
    .DEPTH (FIFO_WORDS)
  ) u_fifo (
    .pclk      (pclk),
    .presetn   (presetn),
    .in_valid  (word_pending),
    .in_ready  (fifo_in_ready),
    .in_data   (word_q),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_out_data)
  );

  // Pop only once the port is free
  assign fifo_pop = fifo_out_valid && !shifting;

  // Nibble serialiser; mode 2 holds each nibble two cycles, others one
  // Doubling suits a slower capture;
  // the index wraps to zero after 3
  // and valid then drops for a cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shift_word        <= 16'h0000;
      nib_idx           <= 2'h0;
      shifting          <= 1'b0;
      mode2_gap         <= 1'b0;
      output_nibble_bus <= 4'h0;
      nibble_valid      <= 1'b0;
    end else begin
      // First nibble on the pop edge
      if (fifo_pop) begin
        shift_word        <= {fifo_out_data[11:0], 4'h0};
        output_nibble_bus <= fifo_out_data[15:12];
        nibble_valid      <= 1'b1;
        nib_idx           <= 2'h1;
        shifting          <= 1'b1;
        mode2_gap         <= cfg[CFG_MODE2_BIT];
      end else if (shifting) begin
        if (mode2_gap) begin
          mode2_gap <= 1'b0;
        end else if (nib_idx == 2'h0) begin
          shifting     <= 1'b0;
          nibble_valid <= 1'b0;
        end else begin
          output_nibble_bus <= shift_word[15:12];
          shift_word        <= {shift_word[11:0], 4'h0};
          nib_idx           <= nib_idx + 2'h1;
          mode2_gap         <= cfg[CFG_MODE2_BIT];
        end
      end
    end
  end
endmodule

// File: adc_code_path_properties.sv
// Purpose: Port-level checks on the scanner front-end code path.
// Assumes: One pclk domain, presetn asynchronous and active low.
// Notes:   Sees only top-level ports; the bind follows the module.
`timescale 1ns/1ps
module adc_code_path_chk (
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  input wire logic       pslverr,
  input wire logic       sample_strobe,
  input wire logic [7:0] offset_dac_code,
  input wire logic       clamp_pulse,
  input wire logic       reset_sample_pulse,
  input wire logic       video_sample_pulse,
  input wire logic       correlated_double_sampling,
  input wire logic       clamp_level_dac_enable,
  input wire logic       reference_level_pin_oe_n,
  input wire logic       nibble_valid
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic vs_d1;
  logic vs_d2;
  // Recent sample history; code changes may trail the sample by two
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vs_d1 <= 1'b0;
      vs_d2 <= 1'b0;
    end else begin
      vs_d1 <= video_sample_pulse;
      vs_d2 <= vs_d1;
    end
  end
  chk_apb_zero_wait: assert property (psel && penable |-> pready)
    else $error("pready missing in access phase");
  chk_ready_one_cycle: assert property (pready |=> !pready)
    else $error("pready held past one cycle");
  chk_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  chk_ref_pin_dac: assert property (clamp_level_dac_enable != reference_level_pin_oe_n)
    else $error("reference pin drive disagrees with clamp DAC enable");
  chk_sample_after_fall: assert property ($fell(sample_strobe) |-> ##[2:5] video_sample_pulse)
    else $error("no sample after strobe fall");
  chk_clamp_near_sample: assert property (clamp_pulse |-> $past(video_sample_pulse)
      || $past(video_sample_pulse, 2) || $past(video_sample_pulse, 3)
      || $past(video_sample_pulse, 4))
    else $error("clamp pulse away from a sample");
  chk_clamp_single: assert property (clamp_pulse |=> !clamp_pulse)
    else $error("clamp pulse longer than one cycle");
  chk_rsmp_needs_cds: assert property (reset_sample_pulse |-> correlated_double_sampling)
    else $error("reset-level sample without CORRELATED_DOUBLE_SAMPLING");
  chk_code_at_sample: assert property ($changed(offset_dac_code)
      |-> ##[0:1] (video_sample_pulse || vs_d1 || vs_d2))
    else $error("offset code changed between samples");
  chk_nibble_len: assert property ($rose(nibble_valid) |-> nibble_valid [*4])
    else $error("word shorter than four nibbles");
  cover property (clamp_pulse);
  cover property ($rose(nibble_valid));
  cover property (pready && pslverr);
endmodule

bind adc_code_path adc_code_path_chk u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
  .pslverr(pslverr), .sample_strobe(sample_strobe), .offset_dac_code(offset_dac_code),
  .clamp_pulse(clamp_pulse), .reset_sample_pulse(reset_sample_pulse),
  .video_sample_pulse(video_sample_pulse),
  .correlated_double_sampling(correlated_double_sampling),
  .clamp_level_dac_enable(clamp_level_dac_enable),
  .reference_level_pin_oe_n(reference_level_pin_oe_n), .nibble_valid(nibble_valid)
);

// File: adc_fifo.sv
// Purpose: Synchronous FIFO for converted words on their way to the nibble port.
// Assumes: One clock; write and read may coincide.
// Notes:   Full and empty are exact; ready on the write side is !full.
`timescale 1ns/1ps
module adc_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("DEPTH must be a power of two");
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;
  logic             push;
  logic             pop;

  // Pointer comparison gives honest full and empty
  assign in_ready  = (wr_ptr ^ rd_ptr) != {1'b1, {AW{1'b0}}};
  assign out_valid = wr_ptr != rd_ptr;
  assign out_data  = mem[rd_ptr[AW-1:0]];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge pclk) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) wr_ptr <= wr_ptr + 1'b1;
      if (pop)  rd_ptr <= rd_ptr + 1'b1;
    end
  end
endmodule

// File: adc_pkg.sv
// Purpose: Shared constants for the scanner front-end digital code path.
// Assumes: 32-bit APB, 100 MHz pclk, registers one aligned word each.
// Notes:   Offsets, reset values and field positions live here only.
package adc_pkg;
  localparam logic [11:0] CFG_OFFSET    = 12'h000;
  localparam logic [11:0] RED_OFFSET    = 12'h004;
  localparam logic [11:0] GREEN_OFFSET  = 12'h008;
  localparam logic [11:0] BLUE_OFFSET   = 12'h00c;
  localparam logic [11:0] STATUS_OFFSET = 12'h010;
  localparam logic [11:0] RESULT_OFFSET = 12'h014;
  localparam logic [31:0] CFG_RESET     = 32'h0000_1f19;
  localparam logic [31:0] COEF_RESET    = 32'h0000_0000;
  // Field positions inside the configuration register
  localparam int CFG_COLOUR_LSB  = 0;   // colour_select [1:0]
  localparam int CFG_MONO_BIT    = 2;
  localparam int CFG_CLAMP_EN    = 3;   // clamp_enable
  localparam int CFG_CDS_BIT     = 4;   // correlated_double_sampling
  localparam int CFG_EXTREF_BIT  = 5;   // external_ref_select
  localparam int CFG_DACRNG_BIT  = 6;   // clamp_dac_range
  localparam int CFG_INVERT_BIT  = 7;   // output_invert
  localparam int CFG_LEVEL_LSB   = 8;   // clamp_level_code [3:0]
  localparam int CFG_POS_LSB     = 12;  // reset_sample_position [1:0]
  localparam int CFG_RANGE_LSB   = 14;  // adc_range_select [1:0]
  localparam int CFG_LAT_LSB     = 16;  // output_latency_select [1:0]
  localparam int CFG_MODE2_BIT   = 18;
  localparam int CFG_WIDTH       = 19;
  localparam logic [16:0] MID_OFFSET = 17'd32767;
  localparam logic [16:0] TOP_OFFSET = 17'd65535;
  localparam logic [15:0] FULL_CODE  = 16'hffff;
  localparam logic [1:0]  RANGE_TOP  = 2'h2;
  localparam logic [1:0]  RANGE_BOT  = 2'h3;
  localparam int CLAMP_BASE_CYCLES   = 1;
  localparam int FIFO_DEPTH          = 32;
endpackage

// File: adc_scan_ctrl.sv
// Purpose: Scanner controller model: pixel strobes out, nibbles in.
// Assumes: Strobe and data change just after a rising pclk edge.
// Notes:   Words land in a queue for the bench to pop.
`timescale 1ns/1ps
module adc_scan_ctrl (
  input  wire logic        pclk,
  input  wire logic        slow,
  input  wire logic [3:0]  output_nibble_bus,
  input  wire logic        nibble_valid,
  output logic             sample_strobe,
  output logic      [16:0] adc_raw
);
  logic [15:0] sh;
  int          cyc;
  logic [15:0] words[$];
  initial begin
    sample_strobe = 1'b0;
    adc_raw       = 17'h0;
    sh            = 16'h0;
    cyc           = 0;
  end
  // One pixel: a one-cycle strobe, value held well past the sample
  task automatic strobe(input logic [16:0] v);
    @(posedge pclk);
    sample_strobe <= 1'b1;
    adc_raw       <= v;
    @(posedge pclk);
    sample_strobe <= 1'b0;
    repeat (6) @(posedge pclk);
    adc_raw <= ~v;  // Stale value must not pass for a fresh one
  endtask
  // Strobes every third cycle, faster than the port drains
  task automatic burst(input int n);
    repeat (n) begin
      @(posedge pclk);
      sample_strobe <= 1'b1;
      adc_raw       <= adc_raw + 17'h01357;
      @(posedge pclk);
      sample_strobe <= 1'b0;
      @(posedge pclk);
    end
  endtask
  // Gather nibbles MSB first; mode 2 holds each two cycles
  always @(posedge pclk) begin
    if (nibble_valid === 1'b1) begin
      if (!slow || cyc[0]) sh <= {sh[11:0], output_nibble_bus};
      cyc <= cyc + 1;
    end else if (cyc != 0) begin
      words.push_back(sh);
      cyc <= 0;
    end
  end
endmodule

// File: test_adc_code_path.sv
// Purpose: Self-checking bench for the scanner front-end code path.
// Assumes: APB master with zero-wait slave, FIFO shrunk to 8 words.
// Notes:   Expected codes come from an integer model of the transfer.
`timescale 1ns/1ps
module test_adc_code_path;
  import adc_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, slow, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, cfg;
  logic        sample_strobe, clamp_pulse, reset_sample_pulse, video_sample_pulse;
  logic        correlated_double_sampling, clamp_level_dac_enable, nb_q;
  logic        reference_level_pin_oe_n, clamp_dac_range, nibble_valid;
  logic [16:0] adc_raw;
  logic [15:0] w;
  logic [7:0]  offset_dac_code, gain_amplifier_code;
  logic [3:0]  clamp_level_code, output_nibble_bus;
  int          n_mismatch, tests_run, seed, cyc, t_vs, t_cl, t_nb, n_cl, n0, cur, d0, r;
  int          coef[3];

  adc_code_path #(.FIFO_WORDS(8)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sample_strobe(sample_strobe), .adc_raw(adc_raw), .offset_dac_code(offset_dac_code),
    .gain_amplifier_code(gain_amplifier_code), .clamp_pulse(clamp_pulse),
    .reset_sample_pulse(reset_sample_pulse), .video_sample_pulse(video_sample_pulse),
    .correlated_double_sampling(correlated_double_sampling),
    .clamp_level_dac_enable(clamp_level_dac_enable),
    .reference_level_pin_oe_n(reference_level_pin_oe_n),
    .clamp_level_code(clamp_level_code), .clamp_dac_range(clamp_dac_range),
    .output_nibble_bus(output_nibble_bus), .nibble_valid(nibble_valid));
  adc_scan_ctrl ctl (
    .pclk(pclk), .slow(slow), .output_nibble_bus(output_nibble_bus),
    .nibble_valid(nibble_valid), .sample_strobe(sample_strobe), .adc_raw(adc_raw));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // Event times for latency and clamp placement
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    nb_q <= nibble_valid;
    if (video_sample_pulse === 1'b1) t_vs <= cyc;
    if (nibble_valid === 1'b1 && nb_q !== 1'b1) t_nb <= cyc;
    if (clamp_pulse === 1'b1) begin
      t_cl <= cyc;
      n_cl <= n_cl + 1;
    end
  end
  // Run is under two thousand cycles; the 20000-cycle limit lies well above it
  initial begin
    repeat (20000) @(posedge pclk);
    n_mismatch++;
    final_report;
  end

  task automatic final_report;
    if (n_mismatch == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    tests_run++;
    if (s !== x) begin
      n_mismatch++;
      $display("FAIL %0t: seen %h expected %h", $time, s, x);
    end
  endtask
  // One APB transfer; held until pready is seen at a rising edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    e  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  // Offset, saturate, then optional inversion
  function automatic logic [15:0] code_of(input int raw, input int rng, input int inv);
    int d;
    d = raw + (rng == 3 ? 0 : (rng == 2 ? 65535 : 32767));
    if (d < 0) d = 0;
    if (d > 65535) d = 65535;
    if (inv != 0) d = 65535 - d;
    return d[15:0];
  endfunction
  // Strobe one pixel and wait, bounded, for its word
  task automatic pixel(input int raw);
    int n;
    ctl.strobe(raw[16:0]);
    n = 0;
    while (ctl.words.size() == 0 && n < 200) begin
      @(posedge pclk);
      n++;
    end
    w = (ctl.words.size() > 0) ? ctl.words.pop_front() : 16'hxxxx;
  endtask

  initial begin
    {presetn, psel, penable, pwrite, slow, nb_q} = 6'h0;
    {paddr, pwdata} = 44'h0;
    {seed, cyc, t_vs, t_cl, t_nb, n_cl, cur, n_mismatch, tests_run} = '0;
    seed = 22343;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, CFG_OFFSET, 32'h0);
    chk(rd, CFG_RESET);
    chk(32'(rd[CFG_CDS_BIT]), 32'h1);
    apb(1'b0, RED_OFFSET, 32'h0);
    chk(rd, COEF_RESET);
    apb(1'b1, 12'h020, 32'h1);
    chk(32'(e), 32'h1);
    // Three stored pairs, each read back
    for (int i = 0; i < 3; i++) begin
      coef[i] = $random(seed) & 32'hffff;
      apb(1'b1, RED_OFFSET + 12'(4 * i), 32'(coef[i]));
      apb(1'b0, RED_OFFSET + 12'(4 * i), 32'h0);
      chk(rd, 32'(coef[i]));
    end
    // Every colour, range and polarity; other fields random except latency, kept at 0
    for (int i = 0; i < 32; i++) begin
      cfg = $random(seed) & 32'h0004_3f7c;
      cfg[CFG_COLOUR_LSB +: 2] = 2'(i % 4);
      cfg[CFG_RANGE_LSB +: 2]  = 2'(i / 4 % 4);
      cfg[CFG_INVERT_BIT]      = i[4];
      apb(1'b1, CFG_OFFSET, cfg);
      slow = cfg[CFG_MODE2_BIT];
      n0 = n_cl;
      r = $random(seed) % 65536;
      pixel(r);
      chk(32'(w), 32'(code_of(r, i / 4 % 4, i / 16)));
      if (cfg[CFG_MONO_BIT]) cur = 0;
      else if (i % 4 != 3) cur = i % 4;
      chk(32'(offset_dac_code), 32'(coef[cur] % 256));
      chk(32'(gain_amplifier_code), 32'(coef[cur] / 256));
      chk(32'(correlated_double_sampling), 32'(cfg[CFG_CDS_BIT]));
      chk(32'({clamp_level_dac_enable, reference_level_pin_oe_n}),
          32'({~cfg[CFG_EXTREF_BIT], cfg[CFG_EXTREF_BIT]}));
      chk(32'({clamp_dac_range, clamp_level_code}),
          32'({cfg[CFG_DACRNG_BIT], cfg[CFG_LEVEL_LSB +: 4]}));
      if (cfg[CFG_CLAMP_EN])
        chk(32'(t_cl - t_vs), 32'(cfg[CFG_POS_LSB +: 2]) + 32'h1);
      else chk(32'(n_cl), 32'(n0));
    end
    // Each latency step adds one cycle before the first nibble
    for (int l = 0; l < 4; l++) begin
      apb(1'b1, CFG_OFFSET, 32'(l) << CFG_LAT_LSB);
      slow = 1'b0;
      pixel(0);
      chk(32'(w), 32'(code_of(0, 0, 0)));
      if (l == 0) d0 = t_nb - t_vs;
      chk(32'(t_nb - t_vs - d0), 32'(l));
    end
    // Overrun the buffer in mode 2, then let it drain
    apb(1'b1, CFG_OFFSET, 32'h1 << CFG_MODE2_BIT);
    slow = 1'b1;
    ctl.burst(40);
    repeat (10) @(posedge pclk);
    apb(1'b0, STATUS_OFFSET, 32'h0);
    chk(32'(rd[2]), 32'h1);
    apb(1'b0, STATUS_OFFSET, 32'h0);
    chk(32'(rd[2]), 32'h0);
    repeat (400) @(posedge pclk);
    apb(1'b0, STATUS_OFFSET, 32'h0);
    chk(32'(rd[1]), 32'h0);
    ctl.words.delete();
    final_report;
  end
endmodule
